// ---- verilog/phwa_host_area.v ----
// Summary of operation
// - Requested screen number word.
// - Word 9: zero shows, ones blank.
// - Year bit 15 toggle loads clock.
// - Control bit 0 dims backlight only.
// - Control bit 1: buzzer.
// - Print, mute, aux, video, cancel bits.
// - Control bit 7: exclusive access.
// - Window bit 0 shows, bit 1 locks.
// - Window number and position from words.
// - Printing status held through print job.
// - Keypad entry inverts set-written status.
// - Exclusive access status bit.
// - Entry range error status.
// - Status bit 9 follows display off.
// - Backlight bit leaves status 9 alone.
// - Copy cancel bit never self-clears.
//
// Decided for this implementation: register access over AXI4-Lite.
`include "phwa_regs.vh"
`default_nettype none
module phwa_host_area (
    input  wire        CORE_CLK,
    input  wire        RST,
    input  wire [31:0] S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [31:0] S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    input  wire        KEY_ENTRY,
    input  wire        KEY_OUT_OF_RANGE,
    input  wire        STANDBY_TIMEOUT,
    input  wire        SCREEN_TOUCH,
    input  wire        MULTI_LINK,
    output reg  [15:0] SCREEN_NUMBER,
    output reg         SCREEN_NUMBER_VALID,
    output reg         DISPLAY_ON,
    output reg         BACKLIGHT_ON,
    output reg         BUZZER,
    output reg         AUX_ENABLE,
    output reg         PRINTING,
    output reg         EXT_VIDEO,
    output reg         EXCLUSIVE_HOST_ACCESS,
    output reg         WINDOW_SHOW,
    output reg         WINDOW_ORDER_LOCK,
    output reg  [15:0] WINDOW_NUMBER,
    output reg  [15:0] WINDOW_X,
    output reg  [15:0] WINDOW_Y,
    output reg         CLOCK_LOAD,
    output reg  [15:0] CLOCK_YEAR,
    output reg  [15:0] CLOCK_MONTH,
    output reg  [15:0] CLOCK_DATE,
    output reg  [15:0] CLOCK_TIME
);
    // ------------------------------------------------------------------
    // Registers and synchronised panel events
    // ------------------------------------------------------------------
    reg [15:0] screen_reg; // Requested screen.
    reg [15:0] display_reg; // Display word.
    reg [15:0] year_reg; // Year and load flag.
    reg [15:0] month_reg; // Month set value.
    reg [15:0] date_reg; // Date set value.
    reg [15:0] time_reg; // Time set value.
    reg [15:0] control_reg; // Control word.
    reg [15:0] win_ctrl_reg; // Window control.
    reg [15:0] win_num_reg; // Window number.
    reg [15:0] win_x_reg; // Window X.
    reg [15:0] win_y_reg; // Window Y.
    reg        bcd_mode_reg; // BCD screen mode.
    reg        flag_last_reg; // Last load flag.
    reg        disp_off_reg; // Display off.
    reg        set_written_reg; // Entry toggle.
    reg        entry_err_reg; // Entry error.
    reg        print_last_reg; // Last print bit.
    reg [15:0] print_cnt_reg; // Print cycles left.
    reg [15:0] screen_last_reg; // Last screen.
    reg [15:0] wdata_hold_reg; // Write data.
    reg [4:0]  waddr_hold_reg; // Write index.
    reg        aw_have_reg; // Address held.
    reg        w_have_reg; // Data held.
    reg        wok_reg; // Address decodes.
    reg        wfull_reg; // Low half strobed.
    reg [15:0] rword; // Read word.
    reg        rok; // Read decodes.
    wire       key_lvl; // Keypad entry.
    wire       oor_lvl; // Out of range.
    wire       stby_lvl; // Standby timeout.
    wire       touch_lvl; // Screen touch.
    wire       multi_lvl; // Multi-link.
    wire       key_rise; // Entry pulse.
    wire       stby_rise; // Standby pulse.
    wire       touch_rise; // Touch pulse.
    wire       do_write; // Write complete.
    wire       print_active; // Job running.
    wire       screen_changed; // Screen changed.
    wire       disp_write; // Display word write.
    wire [4:0] aw_idx; // Write index.
    wire [4:0] ar_idx; // Read index.

    phwa_sync u_sync_key (.CLK(CORE_CLK), .RST(RST), .D(KEY_ENTRY),
        .Q(key_lvl));
    phwa_sync u_sync_oor (.CLK(CORE_CLK), .RST(RST),
        .D(KEY_OUT_OF_RANGE), .Q(oor_lvl));
    phwa_sync u_sync_stby (.CLK(CORE_CLK), .RST(RST),
        .D(STANDBY_TIMEOUT), .Q(stby_lvl));
    phwa_sync u_sync_touch (.CLK(CORE_CLK), .RST(RST),
        .D(SCREEN_TOUCH), .Q(touch_lvl));
    phwa_sync u_sync_multi (.CLK(CORE_CLK), .RST(RST), .D(MULTI_LINK),
        .Q(multi_lvl));
    phwa_edge u_edge_key (.CLK(CORE_CLK), .RST(RST), .D(key_lvl),
        .RISE(key_rise));
    phwa_edge u_edge_stby (.CLK(CORE_CLK), .RST(RST), .D(stby_lvl),
        .RISE(stby_rise));
    phwa_edge u_edge_touch (.CLK(CORE_CLK), .RST(RST), .D(touch_lvl),
        .RISE(touch_rise));

    // ------------------------------------------------------------------
    // Bus slave: write and read channels
    // ------------------------------------------------------------------
    assign aw_idx   = S_AXI_AWADDR[6:2];
    assign ar_idx   = S_AXI_ARADDR[6:2];
    assign do_write = aw_have_reg & w_have_reg & ~S_AXI_BVALID;
    assign disp_write = do_write & wok_reg & wfull_reg &
                        (waddr_hold_reg == `PHWA_IDX_DISPLAY);

    // Take address and data in any order.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            S_AXI_AWREADY  <= 1'b1;
            S_AXI_WREADY   <= 1'b1;
            S_AXI_BVALID   <= 1'b0;
            S_AXI_BRESP    <= `PHWA_RESP_OKAY;
            aw_have_reg    <= 1'b0;
            w_have_reg     <= 1'b0;
            wok_reg        <= 1'b0;
            wfull_reg      <= 1'b0;
            waddr_hold_reg <= 5'h00;
            wdata_hold_reg <= `PHWA_RESET_WORD;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_reg    <= 1'b1;
                S_AXI_AWREADY  <= 1'b0;
                waddr_hold_reg <= aw_idx;
                wok_reg        <= (S_AXI_AWADDR[31:7] == 25'h0) &&
                                  (aw_idx >= `PHWA_IDX_SCREEN) &&
                                  (aw_idx <= `PHWA_IDX_CONFIG);
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_reg     <= 1'b1;
                S_AXI_WREADY   <= 1'b0;
                wdata_hold_reg <= S_AXI_WDATA[15:0];
                wfull_reg      <= S_AXI_WSTRB[0] & S_AXI_WSTRB[1];
            end
            if (do_write) begin
                // Unmapped words answer with a slave error.
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wok_reg ? `PHWA_RESP_OKAY
                                        : `PHWA_RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID  <= 1'b0;
                aw_have_reg   <= 1'b0;
                w_have_reg    <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    // Store a full low-half write.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            screen_reg   <= `PHWA_RESET_SCREEN;
            display_reg  <= `PHWA_RESET_WORD;
            year_reg     <= `PHWA_RESET_WORD;
            month_reg    <= `PHWA_RESET_WORD;
            date_reg     <= `PHWA_RESET_WORD;
            time_reg     <= `PHWA_RESET_WORD;
            control_reg  <= `PHWA_RESET_WORD;
            win_ctrl_reg <= `PHWA_RESET_WORD;
            win_num_reg  <= `PHWA_RESET_WORD;
            win_x_reg    <= `PHWA_RESET_WORD;
            win_y_reg    <= `PHWA_RESET_WORD;
            bcd_mode_reg <= 1'b0;
        end else if (do_write && wok_reg && wfull_reg) begin
            case (waddr_hold_reg)
                `PHWA_IDX_SCREEN:   screen_reg   <= wdata_hold_reg;
                `PHWA_IDX_DISPLAY:  display_reg  <= wdata_hold_reg;
                `PHWA_IDX_YEAR:     year_reg     <= wdata_hold_reg;
                `PHWA_IDX_MONTH:    month_reg    <= wdata_hold_reg;
                `PHWA_IDX_DATE:     date_reg     <= wdata_hold_reg;
                `PHWA_IDX_TIME:     time_reg     <= wdata_hold_reg;
                `PHWA_IDX_CONTROL:  control_reg  <= wdata_hold_reg;
                `PHWA_IDX_WIN_CTRL: win_ctrl_reg <= wdata_hold_reg;
                `PHWA_IDX_WIN_NUM:  win_num_reg  <= wdata_hold_reg;
                `PHWA_IDX_WIN_X:    win_x_reg    <= wdata_hold_reg;
                `PHWA_IDX_WIN_Y:    win_y_reg    <= wdata_hold_reg;
                `PHWA_IDX_CONFIG:   bcd_mode_reg <= wdata_hold_reg[0];
                default:            bcd_mode_reg <= bcd_mode_reg;
            endcase
        end
    end

    // Read mux, status and clock words too.
    always @* begin
        rword = 16'h0000;
        rok   = (S_AXI_ARADDR[31:7] == 25'h0);
        case (ar_idx)
            `PHWA_IDX_CLK_YEAR:  rword = {1'b0, year_reg[14:0]};
            `PHWA_IDX_CLK_MONTH: rword = month_reg;
            `PHWA_IDX_CLK_DATE:  rword = date_reg;
            `PHWA_IDX_CLK_TIME:  rword = time_reg;
            `PHWA_IDX_STATUS: begin
                rword[`PHWA_ST_PRINTING]    = print_active;
                rword[`PHWA_ST_SET_WRITTEN] = set_written_reg;
                rword[`PHWA_ST_EXCL]        = EXCLUSIVE_HOST_ACCESS;
                rword[`PHWA_ST_ENTRY_ERR]   = entry_err_reg;
                rword[`PHWA_ST_DISP_OFF]    = disp_off_reg;
            end
            `PHWA_IDX_SCREEN:   rword = screen_reg;
            `PHWA_IDX_DISPLAY:  rword = display_reg;
            `PHWA_IDX_YEAR:     rword = year_reg;
            `PHWA_IDX_MONTH:    rword = month_reg;
            `PHWA_IDX_DATE:     rword = date_reg;
            `PHWA_IDX_TIME:     rword = time_reg;
            `PHWA_IDX_CONTROL:  rword = control_reg;
            `PHWA_IDX_RESERVED: rword = 16'h0000;
            `PHWA_IDX_WIN_CTRL: rword = win_ctrl_reg;
            `PHWA_IDX_WIN_NUM:  rword = win_num_reg;
            `PHWA_IDX_WIN_X:    rword = win_x_reg;
            `PHWA_IDX_WIN_Y:    rword = win_y_reg;
            `PHWA_IDX_CONFIG:   rword = {15'h0000, bcd_mode_reg};
            default:            rok   = 1'b0;
        endcase
    end

    // Answer a read a cycle after its address.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= `PHWA_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= {16'h0000, rword};
            S_AXI_RRESP   <= rok ? `PHWA_RESP_OKAY : `PHWA_RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Panel behaviour
    // ------------------------------------------------------------------
    assign print_active   = (print_cnt_reg != 16'h0000);
    assign screen_changed = (screen_reg != screen_last_reg);

    // Status flags; a set beats a clear, except that print cancel beats a print start.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            flag_last_reg   <= 1'b0;
            disp_off_reg    <= 1'b0;
            set_written_reg <= 1'b0;
            entry_err_reg   <= 1'b0;
            print_last_reg  <= 1'b0;
            print_cnt_reg   <= 16'h0000;
            screen_last_reg <= `PHWA_RESET_SCREEN;
            CLOCK_LOAD      <= 1'b0;
        end else begin
            flag_last_reg   <= year_reg[`PHWA_YEAR_FLAG];
            screen_last_reg <= screen_reg;
            CLOCK_LOAD <= year_reg[`PHWA_YEAR_FLAG] ^ flag_last_reg;
            if ((disp_write && wdata_hold_reg == `PHWA_DISPLAY_OFF) ||
                stby_rise) begin
                disp_off_reg <= 1'b1;
            end else if ((disp_write && wdata_hold_reg == 16'h0000) ||
                         touch_rise || screen_changed) begin
                disp_off_reg <= 1'b0;
            end
            if (key_rise) begin
                set_written_reg <= ~set_written_reg;
            end
            if (key_rise && oor_lvl) begin
                entry_err_reg <= 1'b1;
            end else if (key_rise || screen_changed) begin
                entry_err_reg <= 1'b0;
            end
            print_last_reg <= control_reg[`PHWA_CTL_PRINT];
            if (control_reg[`PHWA_CTL_PRINT] && !print_last_reg &&
                !print_active && !control_reg[`PHWA_CTL_HC_CANCEL]) begin
                print_cnt_reg <= `PHWA_PRINT_CYCLES;
            end else if (control_reg[`PHWA_CTL_HC_CANCEL]) begin
                print_cnt_reg <= 16'h0000;
            end else if (print_active) begin
                print_cnt_reg <= print_cnt_reg - 16'h0001;
            end
        end
    end

    // Panel outputs follow the stored words.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            SCREEN_NUMBER         <= `PHWA_RESET_SCREEN;
            SCREEN_NUMBER_VALID   <= 1'b0;
            DISPLAY_ON            <= 1'b1;
            BACKLIGHT_ON          <= 1'b1;
            BUZZER                <= 1'b0;
            AUX_ENABLE            <= 1'b1;
            PRINTING              <= 1'b0;
            EXT_VIDEO             <= 1'b0;
            EXCLUSIVE_HOST_ACCESS <= 1'b0;
            WINDOW_SHOW           <= 1'b0;
            WINDOW_ORDER_LOCK     <= 1'b0;
            WINDOW_NUMBER         <= `PHWA_RESET_WORD;
            WINDOW_X              <= `PHWA_RESET_WORD;
            WINDOW_Y              <= `PHWA_RESET_WORD;
            CLOCK_YEAR            <= `PHWA_RESET_WORD;
            CLOCK_MONTH           <= `PHWA_RESET_WORD;
            CLOCK_DATE            <= `PHWA_RESET_WORD;
            CLOCK_TIME            <= `PHWA_RESET_WORD;
        end else begin
            SCREEN_NUMBER       <= screen_reg;
            SCREEN_NUMBER_VALID <= (screen_reg != 16'h0000) &&
                (screen_reg <= (bcd_mode_reg ? `PHWA_SCREEN_MAX_BCD
                                             : `PHWA_SCREEN_MAX_BIN));
            DISPLAY_ON <= ~disp_off_reg;
            BACKLIGHT_ON <= ~control_reg[`PHWA_CTL_BACKLIGHT];
            BUZZER <= control_reg[`PHWA_CTL_BUZZER_ON] &
                      ~control_reg[`PHWA_CTL_BUZZ_DIS];
            AUX_ENABLE <= ~control_reg[`PHWA_CTL_AUX_DIS];
            EXT_VIDEO  <= control_reg[`PHWA_CTL_EXT_VIDEO];
            PRINTING   <= print_active;
            EXCLUSIVE_HOST_ACCESS <= control_reg[`PHWA_CTL_EXCL] &
                                     multi_lvl;
            WINDOW_SHOW       <= win_ctrl_reg[`PHWA_WIN_SHOW];
            WINDOW_ORDER_LOCK <= win_ctrl_reg[`PHWA_WIN_LOCK];
            WINDOW_NUMBER <= win_num_reg;
            WINDOW_X      <= win_x_reg;
            WINDOW_Y      <= win_y_reg;
            // Clock set values follow the stored words.
            CLOCK_YEAR  <= {1'b0, year_reg[14:0]};
            CLOCK_MONTH <= month_reg;
            CLOCK_DATE  <= date_reg;
            CLOCK_TIME  <= time_reg;
        end
    end
endmodule // phwa_host_area
`default_nettype wire

// ---- verilog/phwa_regs.vh ----
`ifndef PHWA_REGS_VH
`define PHWA_REGS_VH
// Word indices; byte address is four times the index.
`define PHWA_IDX_SCREEN      5'h08
`define PHWA_IDX_DISPLAY     5'h09
`define PHWA_IDX_YEAR        5'h0a
`define PHWA_IDX_MONTH       5'h0b
`define PHWA_IDX_DATE        5'h0c
`define PHWA_IDX_TIME        5'h0d
`define PHWA_IDX_CONTROL     5'h0e
`define PHWA_IDX_RESERVED    5'h0f
`define PHWA_IDX_WIN_CTRL    5'h10
`define PHWA_IDX_WIN_NUM     5'h11
`define PHWA_IDX_WIN_X       5'h12
`define PHWA_IDX_WIN_Y       5'h13
// Status, clock readback and config words.
`define PHWA_IDX_STATUS      5'h06
`define PHWA_IDX_CLK_YEAR    5'h02
`define PHWA_IDX_CLK_MONTH   5'h03
`define PHWA_IDX_CLK_DATE    5'h04
`define PHWA_IDX_CLK_TIME    5'h05
`define PHWA_IDX_CONFIG      5'h14
// Control word bit positions.
`define PHWA_CTL_BACKLIGHT   0
`define PHWA_CTL_BUZZER_ON   1
`define PHWA_CTL_PRINT       2
`define PHWA_CTL_BUZZ_DIS    4
`define PHWA_CTL_AUX_DIS     5
`define PHWA_CTL_EXCL        7
`define PHWA_CTL_EXT_VIDEO   8
`define PHWA_CTL_HC_CANCEL   11
// Status bit positions.
`define PHWA_ST_PRINTING     2
`define PHWA_ST_SET_WRITTEN  3
`define PHWA_ST_EXCL         7
`define PHWA_ST_ENTRY_ERR    8
`define PHWA_ST_DISP_OFF     9
// Window control bits and other values.
`define PHWA_WIN_SHOW        0
`define PHWA_WIN_LOCK        1
`define PHWA_YEAR_FLAG       15
`define PHWA_DISPLAY_OFF     16'hffff
`define PHWA_SCREEN_MAX_BIN  16'h232f
`define PHWA_SCREEN_MAX_BCD  16'h07cf
`define PHWA_RESET_WORD      16'h0000
`define PHWA_RESET_SCREEN    16'h0001
`define PHWA_PRINT_CYCLES    16'h0040
`define PHWA_RESP_OKAY       2'b00
`define PHWA_RESP_SLVERR     2'b10
`endif

// ---- verilog/phwa_sync.v ----
`default_nettype none
// Two-stage synchroniser for an outside level.
module phwa_sync (
    input  wire CLK,
    input  wire RST,
    input  wire D,
    output reg  Q
);
    reg meta_reg;  // First stage.

    // Capture and settle the input level.
    always @(posedge CLK) begin
        if (RST) begin
            meta_reg <= 1'b0;
            Q        <= 1'b0;
        end else begin
            meta_reg <= D;
            Q        <= meta_reg;
        end
    end
endmodule // phwa_sync
`default_nettype wire

// ---- verilog/phwa_edge.v ----
`default_nettype none
// Rising edge pulse of a synchronised level.
module phwa_edge (
    input  wire CLK,
    input  wire RST,
    input  wire D,
    output wire RISE
);
    reg last_reg;  // Level seen in the previous cycle.

    // Remember the previous level.
    always @(posedge CLK) begin
        if (RST) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= D;
        end
    end

    assign RISE = D & ~last_reg;
endmodule // phwa_edge
`default_nettype wire

// ---- dv/phwa_props.sv ----
`default_nettype none
// Checker on the host area's ports.
module phwa_props (
    input wire logic        CORE_CLK,
    input wire logic        RST,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [15:0] SCREEN_NUMBER,
    input wire logic        SCREEN_NUMBER_VALID,
    input wire logic        CLOCK_LOAD,
    input wire logic        PRINTING,
    input wire logic        MULTI_LINK,
    input wire logic        EXCLUSIVE_HOST_ACCESS
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    property p_scr;
        SCREEN_NUMBER_VALID |-> SCREEN_NUMBER != 16'h0000
            && SCREEN_NUMBER <= 16'h232f;
    endproperty
    a_scr: assert property (p_scr) else $error("screen range");
    property p_load; CLOCK_LOAD |=> !CLOCK_LOAD; endproperty
    a_load: assert property (p_load) else $error("load pulse");
    property p_prt; $rose(PRINTING) |-> PRINTING [*8]; endproperty
    a_prt: assert property (p_prt) else $error("print held");
    property p_excl; !MULTI_LINK [*4] |-> !EXCLUSIVE_HOST_ACCESS; endproperty
    a_excl: assert property (p_excl) else $error("exclusive");
    property p_bwait; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
    endproperty
    a_bwait: assert property (p_bwait) else $error("write ready");
    property p_bdone; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
    endproperty
    a_bdone: assert property (p_bdone) else $error("write resp");
    property p_rdone; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
    endproperty
    a_rdone: assert property (p_rdone) else $error("read resp");
    property p_rhi; S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000;
    endproperty
    a_rhi: assert property (p_rhi) else $error("read upper");
endmodule // phwa_props
`default_nettype wire

// ---- dv/phwa_plc.sv ----
`default_nettype none
// Host controller model that reads and writes the shared words.
module phwa_plc (
    input  wire logic        clk,
    output var  logic [31:0] awaddr,
    output var  logic        awvalid,
    input  wire logic        awready,
    output var  logic [31:0] wdata,
    output var  logic [3:0]  wstrb,
    output var  logic        wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output var  logic        bready,
    output var  logic [31:0] araddr,
    output var  logic        arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output var  logic        rready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {awaddr, wdata, araddr, wstrb} = '0;
        {awvalid, wvalid, arvalid} = '0;
        {bready, rready} = 2'b11;
    end
    // One word write; each channel is dropped once it is taken.
    task automatic wr(input logic [4:0] i, input logic [15:0] d,
                      output logic [1:0] r);
        awaddr <= {25'h0, i, 2'b00};
        wdata <= {16'h0, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask
    // One word read.
    task automatic rd(input logic [4:0] i, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= {25'h0, i, 2'b00};
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
endmodule // phwa_plc
`default_nettype wire

// ---- dv/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    logic [2:0] ev = 3'h0;
    logic oor = 1'b0;
    logic ml = 1'b0;
    wire logic [31:0] awa, wd, ara, rdt;
    wire logic [3:0] ws;
    wire logic [1:0] br, rr;
    wire logic awv, awr, wv, wrd, bv, bb, arv, arr, rv, rb;
    int fail_count = 0;
    int tests_run = 0;
    int loads = 0;
    logic [31:0] v;
    logic [1:0] r;
    always #50 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) if (DUT.CLOCK_LOAD === 1'b1) loads++;
    phwa_plc P(.clk(CORE_CLK), .awaddr(awa), .awvalid(awv), .awready(awr),
        .wdata(wd), .wstrb(ws), .wvalid(wv), .wready(wrd), .bresp(br),
        .bvalid(bv), .bready(bb), .araddr(ara), .arvalid(arv),
        .arready(arr), .rdata(rdt), .rresp(rr), .rvalid(rv), .rready(rb));
    phwa_host_area DUT(.CORE_CLK(CORE_CLK), .RST(RST), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
        .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bb),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdt), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rb), .KEY_ENTRY(ev[0]), .KEY_OUT_OF_RANGE(oor),
        .STANDBY_TIMEOUT(ev[1]), .SCREEN_TOUCH(ev[2]), .MULTI_LINK(ml),
        .SCREEN_NUMBER(), .SCREEN_NUMBER_VALID(), .DISPLAY_ON(),
        .BACKLIGHT_ON(), .BUZZER(), .AUX_ENABLE(), .PRINTING(),
        .EXT_VIDEO(), .EXCLUSIVE_HOST_ACCESS(), .WINDOW_SHOW(),
        .WINDOW_ORDER_LOCK(), .WINDOW_NUMBER(), .WINDOW_X(), .WINDOW_Y(),
        .CLOCK_LOAD(), .CLOCK_YEAR(), .CLOCK_MONTH(), .CLOCK_DATE(),
        .CLOCK_TIME());
    task automatic cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic w(input logic [4:0] i, input logic [15:0] d);
        P.wr(i, d, r);
        chk("bresp", 32'h0, {30'h0, r});
        cyc(2);
    endtask
    task automatic rd(input logic [4:0] i);
        P.rd(i, v, r);
    endtask
    // Panel event held long enough to pass the synchroniser.
    task automatic pulse(input int b);
        ev[b] <= 1'b1;
        cyc(6);
        ev[b] <= 1'b0;
        cyc(6);
    endtask
    task automatic t_screen;
        w(5'h08, 16'h232f);
        chk("scr", 32'h232f, DUT.SCREEN_NUMBER);
        chk("scr_ok", 32'h1, DUT.SCREEN_NUMBER_VALID);
        w(5'h08, 16'h2330);
        chk("scr_bad", 32'h0, DUT.SCREEN_NUMBER_VALID);
        w(5'h14, 16'h0001);
        w(5'h08, 16'h07d0);
        chk("bcd", 32'h0, DUT.SCREEN_NUMBER_VALID);
        rd(5'h1f);
        chk("unmapped", 32'h2, {30'h0, r});
        rd(5'h0f);
        chk("rsvd", 32'h0, v);
    endtask
    task automatic t_display;
        w(5'h0e, 16'h0001);
        chk("bl", 32'h0, DUT.BACKLIGHT_ON);
        chk("on", 32'h1, DUT.DISPLAY_ON);
        rd(5'h06);
        chk("st9", 32'h0, v[9]);
        w(5'h0e, 16'h0000);
        w(5'h09, 16'hffff);
        chk("off", 32'h0, DUT.DISPLAY_ON);
        rd(5'h06);
        chk("st9", 32'h1, v[9]);
        w(5'h09, 16'h0000);
        chk("on", 32'h1, DUT.DISPLAY_ON);
        pulse(1);
        chk("stby", 32'h0, DUT.DISPLAY_ON);
        pulse(2);
        chk("touch", 32'h1, DUT.DISPLAY_ON);
    endtask
    task automatic t_ctrl;
        logic [15:0] c [4] = '{16'h0002, 16'h0012, 16'h0020, 16'h0100};
        logic [2:0] e [4] = '{3'b110, 3'b010, 3'b000, 3'b011};
        for (int k = 0; k < 4; k++) begin
            w(5'h0e, c[k]);
            chk("ctl", e[k], {DUT.BUZZER, DUT.AUX_ENABLE, DUT.EXT_VIDEO});
        end
        w(5'h0e, 16'h0080);
        chk("ex_off", 32'h0, DUT.EXCLUSIVE_HOST_ACCESS);
        ml <= 1'b1;
        cyc(6);
        chk("ex_on", 32'h1, DUT.EXCLUSIVE_HOST_ACCESS);
        rd(5'h06);
        chk("st7", 32'h1, v[7]);
        ml <= 1'b0;
        w(5'h0e, 16'h0000);
    endtask
    task automatic t_clock;
        int n;
        w(5'h0b, 16'h0010);
        w(5'h0c, 16'h0016);
        w(5'h0d, 16'h2157);
        n = loads;
        w(5'h0a, 16'h8095);
        chk("load", n + 1, loads);
        chk("year", 32'h0095, DUT.CLOCK_YEAR);
        chk("time", 32'h2157, DUT.CLOCK_TIME);
        chk("md", 32'h00100016, {DUT.CLOCK_MONTH, DUT.CLOCK_DATE});
        w(5'h0a, 16'h0095);
        w(5'h0a, 16'h0095);
        chk("load2", n + 2, loads);
    endtask
    task automatic t_print;
        w(5'h0e, 16'h0004);
        chk("prt", 32'h1, DUT.PRINTING);
        cyc(20);
        rd(5'h06);
        chk("st2", 32'h1, v[2]);
        w(5'h0e, 16'h0804);
        chk("abort", 32'h0, DUT.PRINTING);
        rd(5'h0e);
        chk("hc", 32'h0804, v);
        w(5'h0e, 16'h0000);
    endtask
    task automatic t_key;
        logic s;
        rd(5'h06);
        s = v[3];
        pulse(0);
        rd(5'h06);
        chk("setw", {31'h0, ~s}, v[3]);
        oor <= 1'b1;
        pulse(0);
        rd(5'h06);
        chk("err", 32'h1, v[8]);
        oor <= 1'b0;
        pulse(0);
        rd(5'h06);
        chk("err0", 32'h0, v[8]);
    endtask
    task automatic t_win;
        w(5'h10, 16'h0003);
        chk("win", 32'h3, {DUT.WINDOW_ORDER_LOCK, DUT.WINDOW_SHOW});
        w(5'h10, 16'h0000);
        chk("win0", 32'h0, {DUT.WINDOW_ORDER_LOCK, DUT.WINDOW_SHOW});
        for (int k = 0; k < 3; k++) w(5'(17 + k), 16'(256 + k));
        chk("wnum", 32'h0100, DUT.WINDOW_NUMBER);
        chk("wx", 32'h0101, DUT.WINDOW_X);
        chk("wy", 32'h0102, DUT.WINDOW_Y);
    endtask
    task automatic final_report;
        $display("mismatches %0d of %0d checks", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        cyc(5);
        RST <= 1'b0;
        cyc(1);
        t_screen;
        t_display;
        t_ctrl;
        t_clock;
        t_print;
        t_key;
        t_win;
        final_report;
    end
    initial begin
        cyc(20000);
        fail_count++;
        final_report;
    end
endmodule // testbench
bind phwa_host_area phwa_props u_props(.*);
`default_nettype wire
